// >>> bench/test_port_mode_select_and_reset_tb.sv
// bench for tps_top: host path, mode switch and scan access
// assumes tps_defines.svh on the include path
`timescale 1ns/1ps
`include "tps_defines.svh"
module test_port_mode_select_and_reset_tb;
    import tps_pkg::*;
    logic i_clk, i_rst, i_test_sel, i_reset_n, i_host_dout, i_host_dout_en;
    logic ck, di, ms, pin, seen;
    logic o_port_tdo, o_port_tdo_oe, o_port_hdout, o_port_hdout_oe;
    logic o_host_sclk, o_host_sdin, o_host_cs_n, o_core_rst, o_test_mode;
    logic [31:0] word, rnd;
    logic [3:0] cap;
    int num_errors = 0, checks = 0, cycles = 0, seed = 32'h1bff, pass;
    // pin 59 has a pull-up when neither side drives it
    assign pin = o_port_tdo_oe ? o_port_tdo : (o_port_hdout_oe ? o_port_hdout : 1'b1);
    tps_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_test_sel(i_test_sel),
        .i_reset_n(i_reset_n), .i_port_clk(ck), .i_port_din(di), .i_port_mode(ms),
        .i_host_dout(i_host_dout), .i_host_dout_en(i_host_dout_en),
        .o_port_tdo(o_port_tdo), .o_port_tdo_oe(o_port_tdo_oe),
        .o_port_hdout(o_port_hdout), .o_port_hdout_oe(o_port_hdout_oe),
        .o_host_sclk(o_host_sclk), .o_host_sdin(o_host_sdin), .o_host_cs_n(o_host_cs_n),
        .o_core_rst(o_core_rst), .o_test_mode(o_test_mode));
    tps_tester partner (.i_pin(pin), .o_ck(ck), .o_di(di), .o_ms(ms));
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // {sclk, sdin, cs_n, core_rst}: idle in test mode; in host mode pins passed, reset pin inverted
    function automatic logic [3:0] host_exp(logic sel, logic c, logic d, logic m, logic rn);
        return sel ? 4'b0010 : {c, d, m, ~rn};
    endfunction
    task automatic host_chk();
        repeat (5) @(negedge i_clk);
        chk("host outs", host_exp(i_test_sel, ck, di, ms, i_reset_n),
            {o_host_sclk, o_host_sdin, o_host_cs_n, o_core_rst});
        chk("pin59 host", i_test_sel ? 2'b00 : {i_host_dout, i_host_dout_en},
            {o_port_hdout, o_port_hdout_oe});
        chk("test mode", i_test_sel, o_test_mode);
    endtask
    task automatic tap_reset();
        @(negedge i_clk);
        i_reset_n = 1'b0;
        repeat (5) partner.step(1'b1, 1'b0, seen);
        host_chk();
        i_reset_n = 1'b1;
        // two edges of reset sync still hold the machine, third reaches idle
        repeat (3) partner.step(1'b0, 1'b0, seen);
    endtask
    task automatic dr_scan(input int n, input logic [31:0] din, output logic [31:0] dout);
        dout = 32'hFFFFFFFF;
        partner.step(1'b1, 1'b0, seen);
        partner.step(1'b0, 1'b0, seen);
        partner.step(1'b0, 1'b0, seen);
        for (int k = 0; k < n; k++) partner.step(k == n - 1, din[k], dout[k]);
        partner.step(1'b1, 1'b0, seen);
        partner.step(1'b0, 1'b0, seen);
    endtask
    task automatic ir_scan(input logic [3:0] ins, output logic [3:0] got);
        partner.step(1'b1, 1'b0, seen);
        partner.step(1'b1, 1'b0, seen);
        partner.step(1'b0, 1'b0, seen);
        partner.step(1'b0, 1'b0, seen);
        for (int k = 0; k < 4; k++) partner.step(k == 3, ins[k], got[k]);
        partner.step(1'b1, 1'b0, seen);
        partner.step(1'b0, 1'b0, seen);
    endtask
    initial begin
        i_rst = 1'b1;
        i_test_sel = 1'b0;
        i_reset_n = 1'b0; // board holds reset low at start (hold scaled down)
        i_host_dout = 1'b0;
        i_host_dout_en = 1'b0;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        chk("reset outs", 4'b0011, {o_host_sclk, o_host_sdin, o_host_cs_n, o_core_rst});
        i_rst = 1'b0;
        for (pass = 0; pass < 2; pass++) begin
            for (int j = 0; j < 20; j++) begin
                rnd = $random(seed);
                partner.host(rnd[0], rnd[1], rnd[2]);
                {i_host_dout, i_host_dout_en, i_reset_n} = rnd[5:3];
                host_chk();
            end
            {i_host_dout_en, i_reset_n} = 2'b01;
            partner.host(1'b0, 1'b0, 1'b1);
            repeat (3) partner.step(1'b1, 1'b0, seen);
            dr_scan(8, rnd, word);
            chk("scan in host mode", 32'hFFFFFFFF, word);
            @(negedge i_clk);
            i_test_sel = 1'b1;
            tap_reset();
            dr_scan(32, $random(seed), word);
            chk("idcode", `TPS_IDCODE_VAL, word);
            ir_scan(`TPS_INS_BYPASS, cap);
            chk("ir capture", `TPS_IR_CAPT, cap);
            rnd = $random(seed);
            dr_scan(9, rnd, word);
            chk("bypass", {23'h7FFFFF, rnd[7:0], 1'b0}, word);
            tap_reset();
            dr_scan(32, 32'hFFFF0000, word);
            chk("idcode after reset", `TPS_IDCODE_VAL, word);
            @(negedge i_clk);
            i_test_sel = 1'b0;
        end
        print_verdict();
    end
endmodule // test_port_mode_select_and_reset_tb

// >>> bench/tps_tester.sv
// scan tester model: drives the port clock, data in and mode pins
// assumes the bench resolves pin 59 and feeds the level back on i_pin
`timescale 1ns/1ps
module tps_tester (
    input wire logic i_pin,
    output logic o_ck,
    output logic o_di,
    output logic o_ms
);
    initial begin
        o_ck = 1'b0;
        o_di = 1'b0;
        o_ms = 1'b1;
    end
    // one 12 ns port-clock cycle; clock rests low between frames
    task automatic step(input logic ms, input logic di, output logic seen);
        o_ms = ms;
        o_di = di;
        #5;
        seen = i_pin;
        o_ck = 1'b1;
        #6;
        o_ck = 1'b0;
        #1;
    endtask
    // host-mode levels; tester leaves the pins to the host
    task automatic host(input logic ck, input logic di, input logic ms);
        o_ck = ck;
        o_di = di;
        o_ms = ms;
    endtask
endmodule // tps_tester

// >>> common/tps_defines.svh
// constants for the test port mode select and test access logic
// assumes inclusion from the package, the design top and the bench; guarded
`ifndef TPS_DEFINES_SVH
`define TPS_DEFINES_SVH

// ------------------------------------------------------------
// instruction register
// ------------------------------------------------------------
`define TPS_IR_W 4
`define TPS_IR_CAPT 4'h1
`define TPS_IR_RST 4'h1
`define TPS_INS_IDCODE 4'h1
`define TPS_INS_BYPASS 4'hF

// ------------------------------------------------------------
// data register
// ------------------------------------------------------------
`define TPS_DR_W 32
// identity word: arbitrary neutral value
`define TPS_IDCODE_VAL 32'h00000001
`define TPS_DR_RST 32'h00000000

// ------------------------------------------------------------
// reset hold expected from the board (other party)
// ------------------------------------------------------------
`define TPS_RST_HOLD_US 500

`endif

// >>> common/tps_pkg.sv
// types for the test port mode select and test access logic
// assumes tps_defines.svh on the include path
`include "tps_defines.svh"

package tps_pkg;

    // ------------------------------------------------------------
    // test access state machine
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        TAP_TLR = 16'h0001,
        TAP_RTI = 16'h0002,
        TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008,
        TAP_SH_DR = 16'h0010,
        TAP_EX1_DR = 16'h0020,
        TAP_PAU_DR = 16'h0040,
        TAP_EX2_DR = 16'h0080,
        TAP_UPD_DR = 16'h0100,
        TAP_SEL_IR = 16'h0200,
        TAP_CAP_IR = 16'h0400,
        TAP_SH_IR = 16'h0800,
        TAP_EX1_IR = 16'h1000,
        TAP_PAU_IR = 16'h2000,
        TAP_EX2_IR = 16'h4000,
        TAP_UPD_IR = 16'h8000
    } tps_tap_e;

    // ------------------------------------------------------------
    // state of each clock domain
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] sel_s;
        logic [1:0] rst_s;
        logic [1:0] ck_s;
        logic [1:0] di_s;
        logic [1:0] cs_s;
        logic test_mode;
        logic host_sclk;
        logic host_sdin;
        logic host_cs_n;
        logic hdout;
        logic hdout_oe;
        logic core_rst;
    } tps_hst_s;

    typedef struct packed {
        logic [1:0] sel_s;
        logic [1:0] rst_s;
        tps_tap_e state;
        logic [`TPS_IR_W-1:0] ir_sh;
        logic [`TPS_IR_W-1:0] ir;
        logic [`TPS_DR_W-1:0] dr;
        logic tdo;
        logic tdo_oe;
    } tps_tap_s;

endpackage

// >>> design/tps_top.sv
// test port mode select: host port pins become a boundary-scan port
// assumes pins arrive asynchronous; the port clock pin clocks the scan logic
//
// Contract
// - select high turns the host port into the boundary-scan test port.
// - in test mode the four pins carry test clock, data in, data out, mode.
// - in test mode the general reset pin resets the test access logic.
// - scan access works only while select holds the device in test mode.
`timescale 1ns/1ps
`include "tps_defines.svh"

module tps_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_test_sel,
    input wire logic i_reset_n,
    input wire logic i_port_clk,
    input wire logic i_port_din,
    input wire logic i_port_mode,
    input wire logic i_host_dout,
    input wire logic i_host_dout_en,
    output logic o_port_tdo,
    output logic o_port_tdo_oe,
    output logic o_port_hdout,
    output logic o_port_hdout_oe,
    output logic o_host_sclk,
    output logic o_host_sdin,
    output logic o_host_cs_n,
    output logic o_core_rst,
    output logic o_test_mode
);
    import tps_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic tps_tap_e tap_next(input tps_tap_e s, input logic tms);
        tap_next = TAP_TLR;
        case (s)
            TAP_TLR: tap_next = tms ? TAP_TLR : TAP_RTI;
            TAP_RTI: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: tap_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: tap_next = tms ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: tap_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
            default: tap_next = TAP_TLR;
        endcase
    endfunction

    function automatic logic is_idcode(input logic [`TPS_IR_W-1:0] ir);
        is_idcode = (ir == `TPS_INS_IDCODE);
    endfunction

    // ------------------------------------------------------------
    // host side, system clock domain
    // ------------------------------------------------------------
    tps_hst_s hs_r;
    tps_hst_s hs_nxt;

    always_comb begin
        hs_nxt = hs_r;
        hs_nxt.sel_s = {hs_r.sel_s[0], i_test_sel};
        hs_nxt.rst_s = {hs_r.rst_s[0], i_reset_n};
        hs_nxt.ck_s = {hs_r.ck_s[0], i_port_clk};
        hs_nxt.di_s = {hs_r.di_s[0], i_port_din};
        hs_nxt.cs_s = {hs_r.cs_s[0], i_port_mode};
        hs_nxt.test_mode = hs_r.sel_s[1];
        if (hs_r.test_mode) begin
            // host port parked idle so the core sees no traffic
            hs_nxt.host_sclk = 1'b0;
            hs_nxt.host_sdin = 1'b0;
            hs_nxt.host_cs_n = 1'b1;
            hs_nxt.hdout = 1'b0;
            hs_nxt.hdout_oe = 1'b0;
            // reset pin now belongs to the test logic, not the core
            hs_nxt.core_rst = 1'b0;
        end else begin
            hs_nxt.host_sclk = hs_r.ck_s[1];
            hs_nxt.host_sdin = hs_r.di_s[1];
            hs_nxt.host_cs_n = hs_r.cs_s[1];
            hs_nxt.hdout = i_host_dout;
            hs_nxt.hdout_oe = i_host_dout_en;
            // board keeps the pin low long enough for defaults
            hs_nxt.core_rst = ~hs_r.rst_s[1];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hs_r <= '0;
            hs_r.host_cs_n <= 1'b1;
            hs_r.core_rst <= 1'b1;
        end else begin
            hs_r <= hs_nxt;
        end
    end

    assign o_port_hdout = hs_r.hdout;
    assign o_port_hdout_oe = hs_r.hdout_oe;
    assign o_host_sclk = hs_r.host_sclk;
    assign o_host_sdin = hs_r.host_sdin;
    assign o_host_cs_n = hs_r.host_cs_n;
    assign o_core_rst = hs_r.core_rst;
    assign o_test_mode = hs_r.test_mode;

    // host outputs go idle one edge after the mode flag, so wait for it
    host_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (hs_r.test_mode && $past(hs_r.test_mode)) |-> (hs_r.host_cs_n && !hs_r.host_sclk))
        else $error("host port active in test mode");

    mode_follow_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(hs_r.sel_s[1]) |=> hs_r.test_mode ##1 !hs_r.hdout_oe)
        else $error("test mode not entered after select");

    core_rst_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (hs_r.test_mode && $past(hs_r.test_mode)) |-> !hs_r.core_rst)
        else $error("core reset from pin during test mode");

    host_out_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (hs_r.test_mode && $past(hs_r.test_mode)) |-> (!hs_r.hdout_oe && !hs_r.host_sdin))
        else $error("host data driven in test mode");

    // ------------------------------------------------------------
    // test access logic, port clock domain
    // ------------------------------------------------------------
    // the port clock may stop; test reset is seen only on its edges
    tps_tap_s tp_r;
    tps_tap_s tp_nxt;
    logic tp_rst;

    // test reset: pin low or select low holds the machine in reset
    assign tp_rst = ~tp_r.rst_s[1] | ~tp_r.sel_s[1];

    always_comb begin
        tp_nxt = tp_r;
        tp_nxt.sel_s = {tp_r.sel_s[0], i_test_sel};
        tp_nxt.rst_s = {tp_r.rst_s[0], i_reset_n};
        tp_nxt.state = tap_next(tp_r.state, i_port_mode);
        case (tp_r.state)
            TAP_CAP_IR: tp_nxt.ir_sh = `TPS_IR_CAPT;
            TAP_SH_IR: tp_nxt.ir_sh = {i_port_din, tp_r.ir_sh[`TPS_IR_W-1:1]};
            TAP_UPD_IR: tp_nxt.ir = tp_r.ir_sh;
            TAP_CAP_DR: tp_nxt.dr = is_idcode(tp_r.ir) ? `TPS_IDCODE_VAL : `TPS_DR_RST;
            TAP_SH_DR: begin
                if (is_idcode(tp_r.ir)) begin
                    tp_nxt.dr = {i_port_din, tp_r.dr[`TPS_DR_W-1:1]};
                end else begin
                    // every other code acts as the one-bit bypass
                    tp_nxt.dr = {{(`TPS_DR_W-1){1'b0}}, i_port_din};
                end
            end
            default: tp_nxt.ir_sh = tp_r.ir_sh;
        endcase
        // output launched at the rising edge, one edge ahead of the shift
        tp_nxt.tdo_oe = (tp_nxt.state == TAP_SH_DR) || (tp_nxt.state == TAP_SH_IR);
        if (tp_nxt.state == TAP_SH_IR) begin
            tp_nxt.tdo = tp_nxt.ir_sh[0];
        end else if (tp_nxt.state == TAP_SH_DR) begin
            tp_nxt.tdo = tp_nxt.dr[0];
        end else begin
            tp_nxt.tdo = 1'b0;
        end
        if (tp_rst) begin
            tp_nxt.state = TAP_TLR;
            tp_nxt.ir = `TPS_IR_RST;
            tp_nxt.tdo = 1'b0;
            tp_nxt.tdo_oe = 1'b0;
        end else if (tp_r.state == TAP_TLR) begin
            tp_nxt.ir = `TPS_IR_RST;
        end
    end

    // synchronous to the port clock; test reset acts on its next edge
    always_ff @(posedge i_port_clk) begin
        tp_r <= tp_nxt;
    end

    assign o_port_tdo = tp_r.tdo;
    assign o_port_tdo_oe = tp_r.tdo_oe;

    tap_reset_a: assert property (@(posedge i_port_clk)
        $past(tp_rst) |-> (tp_r.state == TAP_TLR && !tp_r.tdo_oe))
        else $error("test reset did not reach reset state");

    tms_five_a: assert property (@(posedge i_port_clk) disable iff (tp_rst)
        i_port_mode [*5] |=> (tp_r.state == TAP_TLR))
        else $error("five mode-high edges did not reach reset state");

    ir_capture_a: assert property (@(posedge i_port_clk) disable iff (tp_rst)
        (tp_r.state == TAP_CAP_IR) |=> (tp_r.ir_sh == `TPS_IR_CAPT)
            && (tp_r.state != TAP_SH_IR || tp_r.tdo == tp_r.ir_sh[0]))
        else $error("instruction capture value wrong");

    idcode_first_a: assert property (@(posedge i_port_clk) disable iff (tp_rst)
        (tp_r.state == TAP_CAP_DR && is_idcode(tp_r.ir) && !i_port_mode)
            |=> (tp_r.tdo_oe && ({31'h0, tp_r.tdo} == (`TPS_IDCODE_VAL & 32'h00000001))))
        else $error("identity word first bit wrong");

    scan_gate_a: assert property (@(posedge i_port_clk)
        !tp_r.sel_s[1] |=> !tp_r.tdo_oe)
        else $error("test data out driven outside test mode");

endmodule // tps_top
